/* verif/tb_top.sv */
// Self-checking register-level testbench for the pulse template shaper
`timescale 1ns/1ps
module tb_top;
    import tps_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [ADDR_W-1:0] s_axi_araddr = '0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic tx_mark = 1'b0;
    logic [6:0] dac_sample;
    logic irq_n;
    int n_errors = 0;
    int n_tests = 0;
    logic [1:0] wresp = 2'h0;
    logic [9:0] ridx [6] = '{IDX_PULSE_SEL, IDX_AMP_SCALE, IDX_RAM_ACCESS,
        IDX_SAMPLE_DATA, IDX_IRQ_ENABLE, IDX_IRQ_STATUS};
    logic [7:0] rexp [6] = '{{4'h0, TPL_RST}, {2'h0, SCAL_RST}, 8'h00,
        8'h00, 8'h00, 8'h00};
    logic [3:0] stpl [8] = '{TPL_T1_399_533, TPL_J1_0_655, TPL_DS1_M7P5,
        TPL_DS1_M22P5, TPL_E1_120, TPL_T1_0_133, TPL_DS1_0DB, TPL_DS1_M15};
    logic [7:0] sexp [8] = '{8'h36, 8'h36, 8'h11, 8'h04, 8'h21, 8'h36,
        8'h36, 8'h20};

    tps_shaper tps_shaper_inst (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .tx_mark, .dac_sample, .irq_n);

    initial begin
        forever #20 aclk = ~aclk;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Interrupt looked at mid-cycle, where it is settled
    task automatic chk_irq(input logic e);
        @(negedge aclk);
        chk({31'h0, irq_n}, {31'h0, e});
        @(posedge aclk);
    endtask

    // Ready is sampled mid-cycle; it only moves on rising edges
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic a_hs;
        logic w_hs;
        logic b_hs;
        int k;
        b_hs = 1'b0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 200 && !b_hs; k++) begin
            @(negedge aclk);
            a_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = s_axi_bvalid && s_axi_bready;
            wresp = s_axi_bresp;
            @(posedge aclk);
            if (a_hs) begin
                s_axi_awvalid <= 1'b0;
            end
            if (w_hs) begin
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b0;
        // One edge passes so a following call never re-raises bready here
        @(posedge aclk);
        if (!b_hs) begin
            n_errors++;
            summarize();
        end
    endtask

    task automatic rd(input logic [9:0] idx, output logic [31:0] d,
                      output logic [1:0] r);
        logic a_hs;
        logic r_hs;
        int k;
        r_hs = 1'b0;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 200 && !r_hs; k++) begin
            @(negedge aclk);
            a_hs = s_axi_arvalid && s_axi_arready;
            r_hs = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (a_hs) begin
                s_axi_arvalid <= 1'b0;
            end
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        if (!r_hs) begin
            n_errors++;
            summarize();
        end
    endtask

    task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        chk(d, exp);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    // Start a RAM access, then poll until done drops
    task automatic ram_op(input logic [7:0] cmd);
        logic [31:0] d;
        logic [1:0] r;
        int k;
        wr(IDX_RAM_ACCESS, cmd);
        d = 32'h80;
        for (k = 0; k < 20 && d[7] !== 1'b0; k++) begin
            rd(IDX_RAM_ACCESS, d, r);
        end
        chk({31'h0, d[7]}, 32'h0);
    endtask

    // One mark held a full interval, so exactly one pulse starts
    task automatic play(input logic [3:0] tpl, input int n,
                        input logic [6:0] v [4], input int off [4]);
        int c;
        int m;
        int first;
        m = 0;
        first = 0;
        wr(IDX_PULSE_SEL, {4'h0, tpl});
        tx_mark <= 1'b1;
        for (c = 0; c < 100; c++) begin
            @(negedge aclk);
            if (dac_sample !== 7'h00) begin
                if (m == 0) begin
                    first = c;
                end
                if (m < 4) begin
                    chk({25'h0, dac_sample}, {25'h0, v[m]});
                    chk(c - first, off[m]);
                end
                m++;
            end
            @(posedge aclk);
            if (c == 15) begin
                tx_mark <= 1'b0;
            end
        end
        chk(m, n);
        rdchk(IDX_IRQ_STATUS, 32'h0);
        $display("test template %h done", tpl);
    endtask

    initial begin
        repeat (60000) @(posedge aclk);
        n_errors++;
        summarize();
    end

    initial begin
        int i;
        logic [31:0] d;
        logic [1:0] r;
        logic sat;
        logic lo;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        chk_irq(1'b1);
        for (i = 0; i < 6; i++) begin
            rdchk(ridx[i], {24'h0, rexp[i]});
        end
        rd(10'h030, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(10'h030, 8'h00);
        chk({30'h0, wresp}, {30'h0, RESP_SLVERR});
        $display("test reset and map done");
        for (i = 0; i < 8; i++) begin
            wr(IDX_PULSE_SEL, {4'h0, stpl[i]});
            rdchk(IDX_AMP_SCALE, {24'h0, sexp[i]});
        end
        wr(IDX_AMP_SCALE, 8'h37);
        chk({30'h0, wresp}, {30'h0, RESP_OKAY});
        rdchk(IDX_AMP_SCALE, 32'h37);
        $display("test scale done");
        wr(IDX_SAMPLE_DATA, 8'h45);
        ram_op(8'h80);
        wr(IDX_SAMPLE_DATA, 8'h55);
        ram_op(8'hA5);
        wr(IDX_SAMPLE_DATA, 8'h00);
        ram_op(8'hE5);
        rdchk(IDX_SAMPLE_DATA, 32'h55);
        play(TPL_RAM_MIN, 2, '{7'h45, 7'h55, 7'h00, 7'h00},
            '{0, 37, 0, 0});
        // Back-to-back marks pile up later intervals past full scale
        wr(IDX_PULSE_SEL, {4'h0, TPL_DS1_M22P5});
        sat = 1'b0;
        lo = 1'b0;
        tx_mark <= 1'b1;
        for (i = 0; i < 96; i++) begin
            @(negedge aclk);
            if (dac_sample === SM_POS_MAX) begin
                sat = 1'b1;
            end
            if (irq_n !== 1'b1) begin
                lo = 1'b1;
            end
            @(posedge aclk);
        end
        tx_mark <= 1'b0;
        chk({31'h0, sat}, 32'h1);
        chk({31'h0, lo}, 32'h0);
        repeat (96) @(posedge aclk);
        rdchk(IDX_IRQ_STATUS, 32'h1);
        wr(IDX_IRQ_ENABLE, 8'h01);
        repeat (2) @(posedge aclk);
        chk_irq(1'b0);
        wr(IDX_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge aclk);
        rdchk(IDX_IRQ_STATUS, 32'h0);
        chk_irq(1'b1);
        $display("test overflow done");
        play(TPL_DS1_0DB, 2, '{7'h17, 7'h42, 7'h00, 7'h00},
            '{0, 16, 0, 0});
        play(TPL_DS1_M15, 3, '{7'h35, 7'h0F, 7'h03, 7'h00},
            '{0, 16, 32, 0});
        play(TPL_DS1_M22P5, 3, '{7'h2C, 7'h1E, 7'h08, 7'h00},
            '{0, 16, 32, 0});
        play(TPL_T1_533_655, 3, '{7'h20, 7'h3F, 7'h43, 7'h00},
            '{0, 1, 16, 0});
        summarize();
    end
endmodule

/* verilog/tps_pkg.sv */
// Constants, types and register map of the transmit pulse template shaper
package tps_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_PULSE_SEL = 10'h023;
    localparam logic [9:0] IDX_AMP_SCALE = 10'h024;
    localparam logic [9:0] IDX_RAM_ACCESS = 10'h025;
    localparam logic [9:0] IDX_SAMPLE_DATA = 10'h026;
    localparam logic [9:0] IDX_IRQ_ENABLE = 10'h034;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h03B;
    localparam int ADDR_W = 12;
    localparam int IDX_LSB = 2;

    // Field positions
    localparam int RA_DONE_BIT = 7;
    localparam int RA_DIR_BIT = 6;
    localparam int RA_UI_LSB = 4;
    localparam int IRQ_OVF_BIT = 0;
    localparam logic RAM_DIR_WRITE = 1'b0;
    localparam logic RAM_DIR_READ = 1'b1;

    // Template codes
    localparam logic [3:0] TPL_E1_75 = 4'h0;
    localparam logic [3:0] TPL_E1_120 = 4'h1;
    localparam logic [3:0] TPL_T1_0_133 = 4'h2;
    localparam logic [3:0] TPL_T1_399_533 = 4'h5;
    localparam logic [3:0] TPL_T1_533_655 = 4'h6;
    localparam logic [3:0] TPL_J1_0_655 = 4'h7;
    localparam logic [3:0] TPL_DS1_0DB = 4'h8;
    localparam logic [3:0] TPL_DS1_M7P5 = 4'h9;
    localparam logic [3:0] TPL_DS1_M15 = 4'hA;
    localparam logic [3:0] TPL_DS1_M22P5 = 4'hB;
    localparam logic [3:0] TPL_RAM_MIN = 4'hC;

    // Standard amplitude scale codes
    localparam logic [5:0] SCAL_E1 = 6'h21;
    localparam logic [5:0] SCAL_T1 = 6'h36;
    localparam logic [5:0] SCAL_M7P5 = 6'h11;
    localparam logic [5:0] SCAL_M15 = 6'h20;
    localparam logic [5:0] SCAL_M22P5 = 6'h04;
    localparam logic [5:0] SCAL_RAM_REF = 6'h20;

    // Reset values and limits
    localparam logic [3:0] TPL_RST = TPL_E1_75;
    localparam logic [5:0] SCAL_RST = SCAL_E1;
    localparam logic [3:0] PHASE_LAST = 4'hF;
    localparam logic [6:0] SM_POS_MAX = 7'h3F;
    localparam logic [6:0] SM_NEG_MAX = 7'h7F;
    localparam logic [6:0] SM_NEG_ZERO = 7'h40;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RAM_IDLE = 2'b01,
        RAM_EXEC = 2'b10
    } tps_ram_st_t;
endpackage

/* verilog/tps_shaper.sv */
// Transmit pulse template shaper with waveform RAM and AXI4-Lite registers
// Behaviour
// - T1 399-533 ft and J1 0-655 ft templates load scale code 110110, 2% steps.
// - The -7.5 dB build-out template loads scale code 010001, 6.25% steps.
// - The -22.5 dB build-out template loads scale code 000100, 25% steps.
// - Overlapping pulses whose scaled sum exceeds the maximum set overflow flag.
// - Overflow flag set and its enable high drive interrupt output low.
// - 0 dB template: UI1 sample 1 is 0010111, UI2 is 1000010, rest zero.
// - -15 dB template sample 1 holds 0000000,0110101,0001111,0000011 per UI.
// - -22.5 dB template sample 1 holds 0000000,0101100,0011110,0001000 per UI.
// - T1 533-655 ft: UI1 sample 2 is 0111111, UI2 sample 1 is 1000011.
// - Samples are 7-bit signed magnitude, +63 to -63, by interval and phase.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module tps_shaper
    import tps_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Line coder mark, one per unit interval, same clock
    input wire logic tx_mark,
    // Converter sample and interrupt
    output logic [6:0] dac_sample,
    output logic irq_n
);
    typedef struct packed {
        logic [3:0] template_select;
        logic [5:0] amplitude_scale;
        logic dir;
        logic [1:0] interval_index;
        logic [3:0] sample_phase_addr;
        logic [6:0] waveform_sample_data;
        logic waveform_overflow_irq_en;
        logic waveform_overflow_flag;
        tps_ram_st_t ram_st;
        logic [63:0][6:0] ram;
        logic [3:0] phase;
        logic [3:0] hist;
        logic [6:0] dac;
        logic irq_n;
        logic aw_full;
        logic [ADDR_W-1:0] awaddr;
        logic w_full;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tps_state_t;

    tps_state_t s;
    tps_state_t n;

    // Standard scale code for each template
    function automatic logic [5:0] std_scale(input logic [3:0] t);
        case (t)
            TPL_E1_75, TPL_E1_120: std_scale = SCAL_E1;
            TPL_DS1_M7P5: std_scale = SCAL_M7P5;
            TPL_DS1_M15: std_scale = SCAL_M15;
            TPL_DS1_M22P5: std_scale = SCAL_M22P5;
            default: std_scale = (t >= TPL_RAM_MIN) ? SCAL_RAM_REF : SCAL_T1;
        endcase
    endfunction

    // Sparse template ROM; entries not listed read as zero
    function automatic logic [6:0] rom_sample(input logic [3:0] t,
            input logic [1:0] u, input logic [3:0] p);
        case ({t, u, p})
            {TPL_DS1_0DB, 2'h0, 4'h0}: rom_sample = 7'h17;
            {TPL_DS1_0DB, 2'h1, 4'h0}: rom_sample = 7'h42;
            {TPL_T1_0_133, 2'h0, 4'h0}: rom_sample = 7'h17;
            {TPL_T1_0_133, 2'h1, 4'h0}: rom_sample = 7'h42;
            {TPL_J1_0_655, 2'h0, 4'h0}: rom_sample = 7'h17;
            {TPL_J1_0_655, 2'h1, 4'h0}: rom_sample = 7'h42;
            {TPL_T1_399_533, 2'h0, 4'h0}: rom_sample = 7'h20;
            {TPL_T1_399_533, 2'h1, 4'h0}: rom_sample = 7'h43;
            {TPL_T1_533_655, 2'h0, 4'h0}: rom_sample = 7'h20;
            {TPL_T1_533_655, 2'h0, 4'h1}: rom_sample = 7'h3F;
            {TPL_T1_533_655, 2'h1, 4'h0}: rom_sample = 7'h43;
            {TPL_DS1_M7P5, 2'h1, 4'h0}: rom_sample = 7'h14;
            {TPL_DS1_M7P5, 2'h2, 4'h0}: rom_sample = 7'h02;
            {TPL_DS1_M15, 2'h1, 4'h0}: rom_sample = 7'h35;
            {TPL_DS1_M15, 2'h2, 4'h0}: rom_sample = 7'h0F;
            {TPL_DS1_M15, 2'h3, 4'h0}: rom_sample = 7'h03;
            {TPL_DS1_M22P5, 2'h1, 4'h0}: rom_sample = 7'h2C;
            {TPL_DS1_M22P5, 2'h2, 4'h0}: rom_sample = 7'h1E;
            {TPL_DS1_M22P5, 2'h3, 4'h0}: rom_sample = 7'h08;
            default: rom_sample = 7'h00;
        endcase
    endfunction

    // Signed magnitude to two's complement
    function automatic logic signed [8:0] sm_to_s(input logic [6:0] v);
        sm_to_s = v[6] ? -$signed({3'h0, v[5:0]}) : $signed({3'h0, v[5:0]});
    endfunction

    // Strobes derived from the registered state
    logic wr_fire;
    logic [9:0] wr_idx;
    logic ram_go;
    logic ovf_clr;
    logic [6:0] cur_ram0;
    assign wr_fire = s.aw_full && s.w_full && !s.bvalid;
    assign wr_idx = s.awaddr[ADDR_W-1:IDX_LSB];
    assign ram_go = wr_fire && wr_idx == IDX_RAM_ACCESS && s.wstrb[0]
        && s.wdata[RA_DONE_BIT] && s.ram_st == RAM_IDLE;
    assign ovf_clr = wr_fire && wr_idx == IDX_IRQ_STATUS && s.wstrb[0]
        && s.wdata[IRQ_OVF_BIT];
    assign cur_ram0 = s.ram[{2'h0, s.phase}];

    logic signed [8:0] sum;
    logic [7:0] mag;
    logic [14:0] lhs;
    logic [14:0] rhs;
    logic ovf_evt;

    always_comb begin
        sum = 9'sh000;
        for (int k = 0; k < 4; k++) begin
            if (s.hist[k]) begin
                if (s.template_select >= TPL_RAM_MIN) begin
                    sum = sum + sm_to_s(s.ram[{k[1:0], s.phase}]);
                end else begin
                    sum = sum + sm_to_s(rom_sample(s.template_select,
                        k[1:0], s.phase));
                end
            end
        end
        mag = sum[8] ? 8'(-sum) : sum[7:0];
        // Compare against the scaled limit so no divider is needed
        lhs = 15'(mag) * 15'(s.amplitude_scale);
        rhs = 15'(SM_POS_MAX) * 15'(std_scale(s.template_select));
        ovf_evt = lhs > rhs;
    end

    always_comb begin
        n = s;
        // Pulse playback, sixteen phases per unit interval
        n.phase = s.phase + 4'h1;
        if (s.phase == PHASE_LAST) begin
            n.hist = {s.hist[2:0], tx_mark};
        end
        if (sum > 9'sd63) begin
            n.dac = SM_POS_MAX;
        end else if (sum < -9'sd63) begin
            n.dac = SM_NEG_MAX;
        end else begin
            n.dac = sum[8] ? {1'b1, 6'(-sum)} : {1'b0, sum[5:0]};
        end
        // Waveform RAM access
        case (s.ram_st)
            RAM_IDLE: n.ram_st = RAM_IDLE;
            RAM_EXEC: begin
                if (s.dir == RAM_DIR_WRITE) begin
                    n.ram[{s.interval_index, s.sample_phase_addr}] =
                        s.waveform_sample_data;
                end else begin
                    n.waveform_sample_data =
                        s.ram[{s.interval_index, s.sample_phase_addr}];
                end
                n.ram_st = RAM_IDLE;
            end
            default: n.ram_st = RAM_IDLE;
        endcase
        // Write channels are held until both have arrived
        if (s_axi_awvalid && s.awready) begin
            n.aw_full = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            n.w_full = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (wr_fire) begin
            n.aw_full = 1'b0;
            n.w_full = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            case (wr_idx)
                IDX_PULSE_SEL: if (s.wstrb[0]) begin
                    n.template_select = s.wdata[3:0];
                    n.amplitude_scale = std_scale(s.wdata[3:0]);
                end
                IDX_AMP_SCALE: if (s.wstrb[0]) begin
                    n.amplitude_scale = s.wdata[5:0];
                end
                IDX_RAM_ACCESS: if (s.wstrb[0] && s.ram_st == RAM_IDLE) begin
                    // Fields frozen while an access executes
                    n.dir = s.wdata[RA_DIR_BIT];
                    n.interval_index = s.wdata[RA_UI_LSB+:2];
                    n.sample_phase_addr = s.wdata[3:0];
                    if (ram_go) begin
                        n.ram_st = RAM_EXEC;
                    end
                end
                IDX_SAMPLE_DATA: if (s.wstrb[0] && s.ram_st == RAM_IDLE) begin
                    n.waveform_sample_data = s.wdata[6:0];
                end
                IDX_IRQ_ENABLE: if (s.wstrb[0]) begin
                    n.waveform_overflow_irq_en = s.wdata[IRQ_OVF_BIT];
                end
                IDX_IRQ_STATUS: n.bresp = RESP_OKAY;
                default: n.bresp = RESP_SLVERR;
            endcase
        end
        // Set wins over a simultaneous write-one clear
        n.waveform_overflow_flag =
            (s.waveform_overflow_flag && !ovf_clr) || ovf_evt;
        n.irq_n = !(n.waveform_overflow_flag
            && n.waveform_overflow_irq_en);
        n.awready = !n.aw_full;
        n.wready = !n.w_full;
        // Read channel, one outstanding read
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = 32'h0000_0000;
            case (s_axi_araddr[ADDR_W-1:IDX_LSB])
                IDX_PULSE_SEL: n.rdata[3:0] = s.template_select;
                IDX_AMP_SCALE: n.rdata[5:0] = s.amplitude_scale;
                IDX_RAM_ACCESS: n.rdata[7:0] = {s.ram_st == RAM_EXEC, s.dir,
                    s.interval_index, s.sample_phase_addr};
                IDX_SAMPLE_DATA: n.rdata[6:0] = s.waveform_sample_data;
                IDX_IRQ_ENABLE: n.rdata[0] = s.waveform_overflow_irq_en;
                IDX_IRQ_STATUS: n.rdata[0] = s.waveform_overflow_flag;
                default: n.rresp = RESP_SLVERR;
            endcase
        end
        n.arready = !n.rvalid;
        if (!aresetn) begin
            n = '0;
            n.template_select = TPL_RST;
            n.amplitude_scale = SCAL_RST;
            n.ram_st = RAM_IDLE;
            n.irq_n = 1'b1;
            n.awready = 1'b1;
            n.wready = 1'b1;
            n.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        s <= n;
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign dac_sample = s.dac;
    assign irq_n = s.irq_n;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence tpl_write(logic [3:0] t);
        wr_fire && wr_idx == IDX_PULSE_SEL && s.wstrb[0] && s.wdata[3:0] == t;
    endsequence

    t1_std_scale_a: assert property (tpl_write(TPL_T1_399_533) |=>
        s.amplitude_scale == 6'h36 ##1 !$stable(s.phase))
        else $error("T1 template did not load scale 110110");
    lbo7_std_scale_a: assert property (tpl_write(TPL_DS1_M7P5) |=>
        s.amplitude_scale == 6'h11)
        else $error("-7.5 dB template did not load scale 010001");
    lbo22_std_scale_a: assert property (tpl_write(TPL_DS1_M22P5) |=>
        s.amplitude_scale == 6'h04 && s.template_select == TPL_DS1_M22P5)
        else $error("-22.5 dB template did not load scale 000100");
    ovf_set_a: assert property (ovf_evt |=> s.waveform_overflow_flag)
        else $error("Overflow did not set the flag");
    irq_level_a: assert property (
        s.waveform_overflow_flag && s.waveform_overflow_irq_en |-> !irq_n)
        else $error("Interrupt not asserted for enabled overflow");

    sequence single_pulse(logic [3:0] t, logic [3:0] h, logic [3:0] p);
        s.template_select == t && s.hist == h && s.phase == p;
    endsequence

    rom_0db_a: assert property (
        single_pulse(TPL_DS1_0DB, 4'h1, 4'h0) |=> dac_sample == 7'h17)
        else $error("0 dB template UI1 sample 1 wrong");
    rom_15db_a: assert property (
        single_pulse(TPL_DS1_M15, 4'h2, 4'h0) |=> dac_sample == 7'h35)
        else $error("-15 dB template UI2 sample 1 wrong");
    rom_22db_a: assert property (
        single_pulse(TPL_DS1_M22P5, 4'h4, 4'h0) |=> dac_sample == 7'h1E)
        else $error("-22.5 dB template UI3 sample 1 wrong");
    rom_655ft_a: assert property (
        single_pulse(TPL_T1_533_655, 4'h1, 4'h1) |=> dac_sample == 7'h3F)
        else $error("T1 533-655 ft UI1 sample 2 wrong");
    sample_format_a: assert property (
        s.template_select >= TPL_RAM_MIN && s.hist == 4'h1
        && cur_ram0 != SM_NEG_ZERO |=> dac_sample == $past(cur_ram0))
        else $error("RAM sample not played in signed magnitude");

    sequence ram_exec_done;
        s.ram_st == RAM_EXEC ##1 s.ram_st == RAM_IDLE;
    endsequence

    ram_done_a: assert property (ram_go |=> ram_exec_done)
        else $error("Done bit did not clear after the access");
    ovf_sticky_a: assert property (
        s.waveform_overflow_flag && !ovf_clr |=> s.waveform_overflow_flag)
        else $error("Overflow flag dropped without a clear");
endmodule
